// >>> etc_pkg.sv
package etc_pkg;
   // register byte offsets on the control bus
   localparam logic [7:0] OFS_SOFT_VEC = 8'h00;
   localparam logic [7:0] OFS_SRC_EN = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_MASK = 8'h0C;
   localparam logic [7:0] OFS_BUSY = 8'h10;
   // reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [1:0] RST_STATUS = 2'h0;
   // status and soft vector enable bit positions
   localparam int STB_SOFT_END = 0;
   localparam int STB_SRC_END = 1;
   localparam int SOFT_EN_BIT = 7;
   // vector and descriptor addressing
   localparam logic [15:0] SOFT_VEC_BASE = 16'h0400;
   localparam logic [15:0] SRC_VEC_BASE = 16'h0420;
   localparam logic [7:0] RAM_PAGE = 8'hFF;
   localparam logic [23:0] DESC_WORD = 24'h000004;
   localparam logic [23:0] DESC_SIZE = 24'h00000C;
   // internal operation cycles per activation
   localparam logic [1:0] INT_CYCLES = 2'h3;
   // first mode word field positions
   localparam int SM_HI = 7;
   localparam int DM_HI = 5;
   localparam int MD_HI = 3;
   localparam int AREA_BIT = 1;
   localparam int SZ_BIT = 0;
   // second mode word field positions
   localparam int CHAIN_BIT = 7;
   localparam int PER_TRANSFER_IRQ_SELECT_BIT = 6;
   // transfer modes
   localparam logic [1:0] MD_NORMAL = 2'h0;
   localparam logic [1:0] MD_REPEAT = 2'h1;
   localparam logic [1:0] MD_BLOCK = 2'h2;
   // address step codes
   localparam logic [1:0] AM_INC = 2'h2;
   localparam logic [1:0] AM_DEC = 2'h3;
   // memory access sizes
   localparam logic [1:0] SZ_BYTE = 2'h0;
   localparam logic [1:0] SZ_WORD = 2'h1;
   localparam logic [1:0] SZ_LONG = 2'h2;
   // axi responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   typedef enum logic [11:0] {
      ST_IDLE = 12'h001,
      ST_VEC = 12'h002,
      ST_RD0 = 12'h004,
      ST_RD1 = 12'h008,
      ST_RD2 = 12'h010,
      ST_DRD = 12'h020,
      ST_DWR = 12'h040,
      ST_WB0 = 12'h080,
      ST_WB1 = 12'h100,
      ST_WB2 = 12'h200,
      ST_INT = 12'h400,
      ST_DONE = 12'h800
   } etc_state_t;
endpackage

// >>> etc_transfer_controller.sv
// Summary of operation
// - descriptor: mode1, source, mode2, destination, count1, count2
// - chained descriptors follow back to back
// - normal mode: one unit, 1..65536 count
// - normal: first count counts, second ignored
// - repeat: reload count and area after last
// - repeat never ends; interrupt only per-transfer select
// - repeat: high byte reload, low byte running
// - block mode: whole block per activation
// - block size 1..256, reloaded with area address
// - non-area address keeps stepping across blocks
// - second count counts blocks, end interrupts
// - chain bit runs next descriptor too
// - chained descriptor: no interrupt, flag untouched
// - vector, six descriptor accesses, data, three internal
// - vector and internal once per activation
// - soft vector = 0x0400 + field shifted left
// - source end clears its enable bit, else its flag; soft enable clears unless end
`timescale 1ns/1ps
module etc_transfer_controller #(
   parameter int NSRC = 8
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite control slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // system bus master
   output logic mem_req,
   output logic mem_we,
   output logic [1:0] mem_size,
   output logic [23:0] mem_addr,
   output logic [31:0] mem_wdata,
   input wire logic mem_ack,
   input wire logic [31:0] mem_rdata,
   // activation sources
   input wire logic [NSRC-1:0] act_req,
   output logic [NSRC-1:0] src_flag_clr,
   // interrupt
   output logic irq
);
   localparam int IW = $clog2(NSRC);

   etc_pkg::etc_state_t st_r, st_nxt;
   logic act_soft_r, end_r, aw_ok_r, w_ok_r, soft_en_r, soft_arm_r;
   logic [IW-1:0] act_idx_r, pick_idx;
   logic pick_ok;
   logic [23:0] desc_r, sar_r, dar_r, sar_nxt, dar_nxt, acc_addr;
   logic [7:0] mra_r, mrb_r, awaddr_r, wbyte_r, mask_r;
   logic [15:0] cra_r, crb_r, cra_nxt, crb_nxt, data_r;
   logic [1:0] int_cnt_r, status_r, status_set, acc_size;
   logic [6:0] soft_vec_r;
   logic [NSRC-1:0] src_en_r;
   logic ack_ok, acc_st, acc_we, end_nxt, blk_more, wr_go, rd_go, rd_stat;
   logic [31:0] acc_wdata;
   logic [1:0] sm, dm, md;
   logic sz, area_src, chain_enable_bit, per_transfer_irq_select;

   assign sm = mra_r[etc_pkg::SM_HI -: 2];
   assign dm = mra_r[etc_pkg::DM_HI -: 2];
   assign md = mra_r[etc_pkg::MD_HI -: 2];
   assign area_src = mra_r[etc_pkg::AREA_BIT];
   assign sz = mra_r[etc_pkg::SZ_BIT];
   assign chain_enable_bit = mrb_r[etc_pkg::CHAIN_BIT];
   assign per_transfer_irq_select = mrb_r[etc_pkg::PER_TRANSFER_IRQ_SELECT_BIT];
   assign ack_ok = mem_req & mem_ack;

   function automatic logic [23:0] step_a(input logic [23:0] a, input logic [1:0] m,
                                          input logic s);
      step_a = a;
      if (m == etc_pkg::AM_INC) begin
         step_a = a + {23'h0, ~s} + {22'h0, s, 1'b0};
      end else if (m == etc_pkg::AM_DEC) begin
         step_a = a - {23'h0, ~s} - {22'h0, s, 1'b0};
      end
   endfunction

   // winds an area address back by n units, n of zero meaning 256
   function automatic logic [23:0] rewind(input logic [23:0] a, input logic [1:0] m,
                                          input logic s, input logic [7:0] n);
      logic [23:0] amt;
      amt = {15'h0, n == 8'h00, n} << s;
      rewind = a;
      if (m == etc_pkg::AM_INC) begin
         rewind = a - amt;
      end else if (m == etc_pkg::AM_DEC) begin
         rewind = a + amt;
      end
   endfunction

   // lowest index wins among enabled sources
   always_comb begin
      pick_ok = 1'b0;
      pick_idx = '0;
      for (int i = NSRC - 1; i >= 0; i--) begin
         if (act_req[i] && src_en_r[i]) begin
            pick_ok = 1'b1;
            pick_idx = IW'(i);
         end
      end
      if (src_flag_clr != '0) begin
         pick_ok = 1'b0;
      end
   end

   // counter and address update at the end of one data write
   always_comb begin
      sar_nxt = step_a(sar_r, sm, sz);
      dar_nxt = step_a(dar_r, dm, sz);
      cra_nxt = cra_r;
      crb_nxt = crb_r;
      end_nxt = per_transfer_irq_select;
      blk_more = 1'b0;
      unique case (md)
         etc_pkg::MD_REPEAT: begin
            if (cra_r[7:0] == 8'h01) begin
               cra_nxt[7:0] = cra_r[15:8];
               if (area_src) begin
                  sar_nxt = rewind(sar_nxt, sm, sz, cra_r[15:8]);
               end else begin
                  dar_nxt = rewind(dar_nxt, dm, sz, cra_r[15:8]);
               end
            end else begin
               cra_nxt[7:0] = cra_r[7:0] - 8'h01;
            end
         end
         etc_pkg::MD_BLOCK: begin
            if (cra_r[7:0] == 8'h01) begin
               cra_nxt[7:0] = cra_r[15:8];
               if (area_src) begin
                  sar_nxt = rewind(sar_nxt, sm, sz, cra_r[15:8]);
               end else begin
                  dar_nxt = rewind(dar_nxt, dm, sz, cra_r[15:8]);
               end
               crb_nxt = crb_r - 16'h0001;
               end_nxt = per_transfer_irq_select | (crb_r == 16'h0001);
            end else begin
               cra_nxt[7:0] = cra_r[7:0] - 8'h01;
               blk_more = 1'b1;
            end
         end
         default: begin
            cra_nxt = cra_r - 16'h0001;
            end_nxt = per_transfer_irq_select | (cra_r == 16'h0001);
         end
      endcase
   end

   // sequencer
   always_comb begin
      st_nxt = st_r;
      unique case (st_r)
         etc_pkg::ST_IDLE:
            if (soft_arm_r || pick_ok) st_nxt = etc_pkg::ST_VEC;
         etc_pkg::ST_VEC: if (ack_ok) st_nxt = etc_pkg::ST_RD0;
         etc_pkg::ST_RD0: if (ack_ok) st_nxt = etc_pkg::ST_RD1;
         etc_pkg::ST_RD1: if (ack_ok) st_nxt = etc_pkg::ST_RD2;
         etc_pkg::ST_RD2: if (ack_ok) st_nxt = etc_pkg::ST_DRD;
         etc_pkg::ST_DRD: if (ack_ok) st_nxt = etc_pkg::ST_DWR;
         etc_pkg::ST_DWR:
            if (ack_ok) st_nxt = blk_more ? etc_pkg::ST_DRD : etc_pkg::ST_WB0;
         etc_pkg::ST_WB0: if (ack_ok) st_nxt = etc_pkg::ST_WB1;
         etc_pkg::ST_WB1: if (ack_ok) st_nxt = etc_pkg::ST_WB2;
         etc_pkg::ST_WB2:
            if (ack_ok) st_nxt = chain_enable_bit ? etc_pkg::ST_RD0 : etc_pkg::ST_INT;
         etc_pkg::ST_INT:
            if (int_cnt_r == etc_pkg::INT_CYCLES) st_nxt = etc_pkg::ST_DONE;
         etc_pkg::ST_DONE: st_nxt = etc_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r <= etc_pkg::ST_IDLE;
         int_cnt_r <= 2'h0;
      end else begin
         st_r <= st_nxt;
         int_cnt_r <= (st_r == etc_pkg::ST_INT) ? int_cnt_r + 2'h1 : 2'h1;
      end
   end

   // access address, size and write data per state
   always_comb begin
      acc_st = 1'b1;
      acc_we = 1'b0;
      acc_size = etc_pkg::SZ_LONG;
      acc_addr = desc_r;
      acc_wdata = {mra_r, sar_r};
      unique case (st_r)
         etc_pkg::ST_VEC: begin
            acc_size = etc_pkg::SZ_WORD;
            acc_addr = act_soft_r ?
               {8'h00, etc_pkg::SOFT_VEC_BASE + {8'h00, soft_vec_r, 1'b0}}
               : {8'h00, etc_pkg::SRC_VEC_BASE + 16'({act_idx_r, 1'b0})};
         end
         etc_pkg::ST_RD0: acc_addr = desc_r;
         etc_pkg::ST_RD1: acc_addr = desc_r + etc_pkg::DESC_WORD;
         etc_pkg::ST_RD2: acc_addr = desc_r + (etc_pkg::DESC_WORD << 1);
         etc_pkg::ST_DRD: begin
            acc_size = sz ? etc_pkg::SZ_WORD : etc_pkg::SZ_BYTE;
            acc_addr = sar_r;
         end
         etc_pkg::ST_DWR: begin
            acc_we = 1'b1;
            acc_size = sz ? etc_pkg::SZ_WORD : etc_pkg::SZ_BYTE;
            acc_addr = dar_r;
            acc_wdata = {16'h0000, data_r};
         end
         etc_pkg::ST_WB0: acc_we = 1'b1;
         etc_pkg::ST_WB1: begin
            acc_we = 1'b1;
            acc_addr = desc_r + etc_pkg::DESC_WORD;
            acc_wdata = {mrb_r, dar_r};
         end
         etc_pkg::ST_WB2: begin
            acc_we = 1'b1;
            acc_addr = desc_r + (etc_pkg::DESC_WORD << 1);
            acc_wdata = {cra_r, crb_r};
         end
         default: acc_st = 1'b0;
      endcase
   end

   // bus master: request held until acknowledged
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mem_req <= 1'b0;
         mem_we <= 1'b0;
         mem_size <= etc_pkg::SZ_BYTE;
         mem_addr <= 24'h000000;
         mem_wdata <= 32'h00000000;
      end else if (ack_ok) begin
         mem_req <= 1'b0;
      end else if (acc_st && !mem_req) begin
         mem_req <= 1'b1;
         mem_we <= acc_we;
         mem_size <= acc_size;
         mem_addr <= acc_addr;
         mem_wdata <= acc_wdata;
      end
   end

   // activation and descriptor state
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         act_soft_r <= 1'b0;
         act_idx_r <= '0;
         desc_r <= 24'h000000;
         {mra_r, sar_r, mrb_r, dar_r} <= 64'h0000000000000000;
         {cra_r, crb_r, data_r} <= 48'h000000000000;
         end_r <= 1'b0;
      end else begin
         if (st_r == etc_pkg::ST_IDLE) begin
            act_soft_r <= soft_arm_r;
            act_idx_r <= pick_idx;
         end
         if (ack_ok) begin
            unique case (st_r)
               etc_pkg::ST_VEC: desc_r <= {etc_pkg::RAM_PAGE, mem_rdata[15:0]};
               etc_pkg::ST_RD0: {mra_r, sar_r} <= mem_rdata;
               etc_pkg::ST_RD1: {mrb_r, dar_r} <= mem_rdata;
               etc_pkg::ST_RD2: {cra_r, crb_r} <= mem_rdata;
               etc_pkg::ST_DRD: data_r <= sz ? mem_rdata[15:0] : {8'h00, mem_rdata[7:0]};
               etc_pkg::ST_DWR: begin
                  sar_r <= sar_nxt;
                  dar_r <= dar_nxt;
                  cra_r <= cra_nxt;
                  crb_r <= crb_nxt;
                  end_r <= end_nxt;
               end
               etc_pkg::ST_WB2: if (chain_enable_bit) desc_r <= desc_r + etc_pkg::DESC_SIZE;
               default: ;
            endcase
         end
      end
   end

   // axi4-lite write channel
   assign wr_go = aw_ok_r && w_ok_r && !s_axi_bvalid;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         aw_ok_r <= 1'b0;
         w_ok_r <= 1'b0;
         awaddr_r <= 8'h00;
         wbyte_r <= 8'h00;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= etc_pkg::RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            aw_ok_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            w_ok_r <= 1'b1;
            wbyte_r <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
         end
         if (wr_go) begin
            aw_ok_r <= 1'b0;
            w_ok_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awaddr_r == etc_pkg::OFS_SOFT_VEC || awaddr_r == etc_pkg::OFS_SRC_EN
               || awaddr_r == etc_pkg::OFS_MASK) ? etc_pkg::RESP_OKAY : etc_pkg::RESP_DECERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // control registers; a software write lands after the hardware clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         soft_en_r <= 1'b0;
         soft_arm_r <= 1'b0;
         soft_vec_r <= 7'h00;
         src_en_r <= '0;
         mask_r <= etc_pkg::RST_BYTE;
         src_flag_clr <= '0;
      end else begin
         src_flag_clr <= '0;
         if (st_r == etc_pkg::ST_IDLE && soft_arm_r) begin
            soft_arm_r <= 1'b0;
         end
         if (st_r == etc_pkg::ST_DONE) begin
            if (act_soft_r && !end_r) begin
               soft_en_r <= 1'b0;
            end else if (!act_soft_r && end_r) begin
               src_en_r[act_idx_r] <= 1'b0;
            end else if (!act_soft_r) begin
               src_flag_clr[act_idx_r] <= 1'b1;
            end
         end
         if (wr_go) begin
            if (awaddr_r == etc_pkg::OFS_SOFT_VEC && !(soft_en_r && wbyte_r[7])) begin
               soft_en_r <= wbyte_r[etc_pkg::SOFT_EN_BIT];
               soft_arm_r <= wbyte_r[etc_pkg::SOFT_EN_BIT];
               soft_vec_r <= wbyte_r[6:0];
            end
            if (awaddr_r == etc_pkg::OFS_SRC_EN) src_en_r <= wbyte_r[NSRC-1:0];
            if (awaddr_r == etc_pkg::OFS_MASK) mask_r <= wbyte_r;
         end
      end
   end

   // status: set by the end of an activation, cleared by its read; set wins
   assign rd_go = s_axi_arvalid && s_axi_arready;
   assign rd_stat = rd_go && s_axi_araddr == etc_pkg::OFS_STATUS;
   always_comb begin
      status_set = 2'h0;
      if (st_r == etc_pkg::ST_DONE && end_r) begin
         status_set[etc_pkg::STB_SOFT_END] = act_soft_r;
         status_set[etc_pkg::STB_SRC_END] = !act_soft_r;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status_r <= etc_pkg::RST_STATUS;
         irq <= 1'b0;
      end else begin
         status_r <= (rd_stat ? 2'h0 : status_r) | status_set;
         irq <= |(((rd_stat ? 2'h0 : status_r) | status_set) & mask_r[1:0]);
      end
   end

   // axi4-lite read channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= etc_pkg::RESP_OKAY;
      end else begin
         if (rd_go) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= etc_pkg::RESP_OKAY;
            unique case (s_axi_araddr)
               etc_pkg::OFS_SOFT_VEC: s_axi_rdata <= {24'h0, soft_en_r, soft_vec_r};
               etc_pkg::OFS_SRC_EN: s_axi_rdata <= 32'(src_en_r);
               etc_pkg::OFS_STATUS: s_axi_rdata <= {30'h0, status_r};
               etc_pkg::OFS_MASK: s_axi_rdata <= {24'h0, mask_r};
               etc_pkg::OFS_BUSY: s_axi_rdata <= {31'h0, st_r != etc_pkg::ST_IDLE};
               default: begin
                  s_axi_rdata <= 32'h00000000;
                  s_axi_rresp <= etc_pkg::RESP_DECERR;
               end
            endcase
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_wr_done;
      st_r == etc_pkg::ST_DWR && ack_ok;
   endsequence
   sequence s_int_run;
      (st_r == etc_pkg::ST_INT) [*3] ##1 st_r == etc_pkg::ST_DONE;
   endsequence

   AST_SOFT_VEC: assert property (st_r == etc_pkg::ST_VEC && mem_req && act_soft_r |->
      mem_addr == {8'h00, 16'h0400 + {8'h00, soft_vec_r, 1'b0}})
      else $error("soft vector address wrong");
   AST_DESC_RD1: assert property (st_r == etc_pkg::ST_RD1 && mem_req |->
      mem_addr == desc_r + 24'h4 && !mem_we)
      else $error("second descriptor word address wrong");
   AST_CHAIN_NEXT: assert property (st_r == etc_pkg::ST_WB2 && ack_ok && chain_enable_bit |=>
      st_r == etc_pkg::ST_RD0 && desc_r == $past(desc_r) + 24'hC)
      else $error("chained descriptor not consecutive");
   AST_NORMAL_CNT: assert property (s_wr_done and md == etc_pkg::MD_NORMAL |=>
      cra_r == $past(cra_r) - 16'h1 && crb_r == $past(crb_r))
      else $error("normal mode count wrong");
   AST_REPEAT_LOAD: assert property (s_wr_done and md == etc_pkg::MD_REPEAT
      && cra_r[7:0] == 8'h01 |=> cra_r[7:0] == cra_r[15:8])
      else $error("repeat count not reloaded");
   AST_REPEAT_QUIET: assert property (s_wr_done and md == etc_pkg::MD_REPEAT && !per_transfer_irq_select
      |=> !end_r)
      else $error("repeat mode ended");
   AST_BLOCK_END: assert property (s_wr_done and md == etc_pkg::MD_BLOCK
      && cra_r[7:0] == 8'h01 |=> crb_r == $past(crb_r) - 16'h1
      && cra_r[7:0] == cra_r[15:8] && st_r == etc_pkg::ST_WB0)
      else $error("block end handling wrong");
   AST_BLOCK_MORE: assert property (s_wr_done and md == etc_pkg::MD_BLOCK
      && cra_r[7:0] != 8'h01 |=> st_r == etc_pkg::ST_DRD ##[1:300] mem_req)
      else $error("block stopped early");
   AST_INT_THREE: assert property ($rose(st_r == etc_pkg::ST_INT) |-> s_int_run)
      else $error("internal phase not three cycles");
   AST_CHAIN_QUIET: assert property (st_r == etc_pkg::ST_WB2 && ack_ok && chain_enable_bit |=>
      src_flag_clr == '0 && status_set == 2'h0)
      else $error("chained descriptor signalled");
   AST_SOFT_HOLD: assert property (st_r == etc_pkg::ST_DONE && act_soft_r && end_r |=>
      soft_en_r || $past(wr_go))
      else $error("soft enable dropped at end");
   AST_WRITEBACK: assert property (st_r == etc_pkg::ST_WB2 && mem_req |->
      mem_we && mem_wdata == {cra_r, crb_r})
      else $error("count write-back wrong");
endmodule

// >>> etc_mem_model.sv
`timescale 1ns/1ps
module etc_mem_model (
   // clock
   input wire logic aclk,
   // system bus slave
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [1:0] mem_size,
   input wire logic [23:0] mem_addr,
   input wire logic [31:0] mem_wdata,
   output logic mem_ack,
   output logic [31:0] mem_rdata,
   // extra wait cycles per access
   input wire logic [3:0] wait_cyc
);
   logic [7:0] m [int];
   int cnt = 0;
   int nacc = 0;
   function automatic logic [7:0] rd(input int a);
      return m.exists(a) ? m[a] : 8'hA5;
   endfunction
   initial begin
      mem_ack = 1'b0;
      mem_rdata = 32'h0;
   end
   // big-endian lanes; idle data toggles so a stale word never looks valid
   always @(posedge aclk) begin : serve
      logic [31:0] d;
      int n;
      n = 1 << mem_size;
      d = 32'h0;
      if (mem_ack || !mem_req || cnt < wait_cyc) begin
         mem_ack <= 1'b0;
         mem_rdata <= ~mem_rdata;
         cnt = (mem_req && !mem_ack) ? cnt + 1 : 0;
      end else begin
         for (int i = 0; i < n; i++) begin
            if (mem_we) m[mem_addr + i] = mem_wdata[8 * (n - 1 - i) +: 8];
            else d = {d[23:0], rd(mem_addr + i)};
         end
         mem_rdata <= d;
         mem_ack <= 1'b1;
         nacc++;
         cnt = 0;
      end
   end
endmodule

// >>> test_etc_transfer_controller.sv
`timescale 1ns/1ps
module test_etc_transfer_controller;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic [7:0] s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0;
   logic [7:0] act_req = 8'h00;
   logic [3:0] wait_cyc = 4'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic mem_req, mem_we, mem_ack, irq;
   logic [1:0] s_axi_bresp, s_axi_rresp, mem_size;
   logic [23:0] mem_addr;
   logic [31:0] s_axi_rdata, mem_wdata, mem_rdata;
   logic [7:0] src_flag_clr;
   int miscompares = 0;
   int n_checks = 0;
   int a0 = 0;
   int nclr = 0;
   always #12.5 aclk = ~aclk;
   etc_transfer_controller #(.NSRC(8)) i_etc_transfer_controller (.aclk, .aresetn,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .mem_req, .mem_we, .mem_size, .mem_addr, .mem_wdata,
      .mem_ack, .mem_rdata, .act_req, .src_flag_clr, .irq);
   etc_mem_model i_etc_mem_model (.aclk, .mem_req, .mem_we, .mem_size, .mem_addr,
      .mem_wdata, .mem_ack, .mem_rdata, .wait_cyc);
   // a source flag drops once the controller clears it
   always @(posedge aclk) if (src_flag_clr != 8'h00) begin
      act_req <= act_req & ~src_flag_clr;
      nclr <= nclr + 1;
   end
   task automatic summarize();
      $display("checks %0d, miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected %s: expected %h, seen %h", nm, e, g);
      end
   endtask
   task automatic tmo();
      miscompares++;
      summarize();
   endtask
   function automatic logic [31:0] xresp(input logic [7:0] a);
      return (a > etc_pkg::OFS_BUSY) ? etc_pkg::RESP_DECERR : etc_pkg::RESP_OKAY;
   endfunction
   task automatic wc(input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      k = 0;
      do begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
         if (++k > 100) tmo();
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      chk("bresp", xresp(a), s_axi_bresp);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      int k;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      k = 0;
      do begin
         @(posedge aclk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
         if (++k > 100) tmo();
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      d = s_axi_rdata;
      chk("rresp", xresp(a), s_axi_rresp);
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      rd(a, d);
      chk($sformatf("reg %h", a), e, d);
   endtask
   task automatic put(input int a, input logic [31:0] v, input int n);
      for (int i = 0; i < n; i++) i_etc_mem_model.m[a + i] = v[8 * (n - 1 - i) +: 8];
   endtask
   task automatic desc(input int a, input logic [31:0] w0, w1, w2);
      put(a, w0, 4);
      put(a + 4, w1, 4);
      put(a + 8, w2, 4);
   endtask
   task automatic mc(input int a, input logic [31:0] e);
      logic [31:0] g;
      for (int i = 0; i < 4; i++) g = {g[23:0], i_etc_mem_model.rd(a + i)};
      chk($sformatf("mem %h", a), e, g);
   endtask
   task automatic see_irq(input logic e);
      repeat (2) @(posedge aclk);
      chk("irq", {31'h0, e}, {31'h0, irq});
   endtask
   // waits for the access count, then for busy to fall, then checks the count
   task automatic fin(input int n);
      logic [31:0] d;
      int k;
      for (k = 0; i_etc_mem_model.nacc < a0 + n; k++) begin
         if (k > 3000) tmo();
         @(posedge aclk);
      end
      k = 0;
      do begin
         rd(etc_pkg::OFS_BUSY, d);
         if (++k > 50) tmo();
      end while (d[0] !== 1'b0);
      chk("accesses", a0 + n, i_etc_mem_model.nacc);
      a0 = i_etc_mem_model.nacc;
   endtask
   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      for (int a = 0; a < 24; a += 4) rc(a[7:0], 32'h0);
      wc(8'h14, 32'hFF);
      put(16'h0420, 32'hEC00, 2);
      desc(24'hFFEC00, 32'hA0001000, 32'h00002000, 32'h00020000);
      put(24'h001000, 32'h5AC3, 2);
      wc(etc_pkg::OFS_MASK, 32'h1);
      wc(etc_pkg::OFS_SOFT_VEC, 32'h90);
      fin(9);
      mc(24'hFFEC00, 32'hA0001001);
      mc(24'hFFEC04, 32'h00002001);
      mc(24'hFFEC08, 32'h00010000);
      rc(etc_pkg::OFS_SOFT_VEC, 32'h10);
      rc(etc_pkg::OFS_STATUS, 32'h0);
      wc(etc_pkg::OFS_SOFT_VEC, 32'h90);
      fin(9);
      mc(24'hFFEC08, 32'h00000000);
      mc(24'h002000, 32'h5AC3A5A5);
      rc(etc_pkg::OFS_SOFT_VEC, 32'h90);
      wc(etc_pkg::OFS_SOFT_VEC, 32'h95);
      rc(etc_pkg::OFS_SOFT_VEC, 32'h90);
      see_irq(1'b1);
      wc(etc_pkg::OFS_MASK, 32'h0);
      see_irq(1'b0);
      rc(etc_pkg::OFS_STATUS, 32'h1);
      wc(etc_pkg::OFS_MASK, 32'h1);
      see_irq(1'b0);
      wc(etc_pkg::OFS_SOFT_VEC, 32'h00);
      put(16'h0422, 32'hEC10, 2);
      desc(24'hFFEC10, 32'h24001100, 32'h00002100, 32'h02010000);
      put(24'h001100, 32'h3C, 1);
      wait_cyc <= 4'h3;
      wc(etc_pkg::OFS_SRC_EN, 32'h2);
      act_req <= 8'h02;
      fin(9);
      chk("flag clears", 32'h1, nclr);
      rc(etc_pkg::OFS_SRC_EN, 32'h2);
      mc(24'hFFEC14, 32'h000020FF);
      mc(24'hFFEC18, 32'h02020000);
      mc(24'h002100, 32'h3CA5A5A5);
      rc(etc_pkg::OFS_STATUS, 32'h0);
      desc(24'hFFEC10, 32'hC7001402, 32'h40002400, 32'h01010000);
      put(24'h001402, 32'hBEEF, 2);
      act_req <= 8'h02;
      fin(9);
      mc(24'hFFEC10, 32'hC7001402);
      mc(24'hFFEC18, 32'h01010000);
      mc(24'h002400, 32'hBEEFA5A5);
      rc(etc_pkg::OFS_SRC_EN, 32'h0);
      rc(etc_pkg::OFS_STATUS, 32'h2);
      wait_cyc <= 4'h0;
      put(16'h0430, 32'hEC20, 2);
      desc(24'hFFEC20, 32'hA0001200, 32'h80002200, 32'h00010000);
      desc(24'hFFEC2C, 32'hA8001300, 32'h00002300, 32'h02020002);
      put(24'h001200, 32'h77, 1);
      put(24'h001300, 32'h1122, 2);
      wc(etc_pkg::OFS_SOFT_VEC, 32'h98);
      fin(19);
      mc(24'hFFEC28, 32'h00000000);
      mc(24'h002200, 32'h77A5A5A5);
      mc(24'hFFEC2C, 32'hA8001302);
      mc(24'hFFEC30, 32'h00002300);
      mc(24'hFFEC34, 32'h02020001);
      mc(24'h002300, 32'h1122A5A5);
      rc(etc_pkg::OFS_STATUS, 32'h0);
      rc(etc_pkg::OFS_SOFT_VEC, 32'h18);
      summarize();
   end
endmodule
